// ===== rtl/fwer_mem.v
// simple dual port memory with registered read data
`timescale 1ns/1ps
module fwer_mem #(
  parameter W  = 32,
  parameter D  = 1600,
  parameter AW = 11
) (
  input  wire          clk,
  input  wire          ce,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [W-1:0]  wrData,
  input  wire          rdEn,
  input  wire [AW-1:0] rdAddr,
  output wire [W-1:0]  rdData
);
  reg [W-1:0] mem [0:D-1];
  reg [W-1:0] rdData_q;

  // read data holds while rdEn is low so a stalled reader keeps its word
  always @(posedge clk) begin
    if (ce) begin
      if (wrEn)
        mem[wrAddr] <= wrData;
      if (rdEn)
        rdData_q <= mem[rdAddr];
    end
  end

  assign rdData = rdData_q;
endmodule

// ===== rtl/fwer_regs.vh
// constants of the fault waveform and event recorder
`ifndef FWER_REGS_VH
`define FWER_REGS_VH

// ************************************************
// sample path
// ************************************************
`define FWER_SMP_W      16
`define FWER_SPC        32
`define FWER_LINE_HZ    50
`define FWER_CLK_HZ     40000000

// ************************************************
// waveform records
// ************************************************
`define FWER_PRE_CYC    45
`define FWER_POST_CYC   5
`define FWER_REC_CYC    50
`define FWER_NUM_REC    200
`define FWER_HDR_WORDS  4
`define FWER_WORD_W     11
`define FWER_SLOT_W     8
`define FWER_WORD_BITS  32

// ************************************************
// event log and time of day
// ************************************************
`define FWER_NUM_EVT    5000
`define FWER_EVT_AW     13
`define FWER_STAMP_MS   1
`define FWER_MS_PER_S   1000
`define FWER_TIME_W     48
`define FWER_CODE_W     4
`define FWER_ARG_W      32
`define FWER_CNT_W      16
`define FWER_NUM_CODES  9
`define FWER_EV_TRIP    0
`define FWER_EV_TCS     1
`define FWER_EV_PICKUP  2
`define FWER_EV_RESET   3
`define FWER_EV_CBTRIP  4
`define FWER_EV_CBCLOSE 5
`define FWER_EV_STATUS  6
`define FWER_EV_SETTING 7
`define FWER_EV_FAIL    8

`endif

// ===== rtl/fwer_top.v
// fault waveform capture, event log and element counters
`timescale 1ns/1ps
`include "fwer_regs.vh"
module fwer_top #(
  parameter [31:0] SAMPLE_TICKS = `FWER_CLK_HZ / (`FWER_LINE_HZ * `FWER_SPC),
  parameter [31:0] MS_TICKS     =
    `FWER_CLK_HZ / `FWER_MS_PER_S * `FWER_STAMP_MS,
  parameter        NUM_ELEM     = 1
) (
  input  wire                        clk,
  input  wire                        rst,
  input  wire                        ce,
  output wire                        adcConvert,
  input  wire                        adcDone,
  input  wire [`FWER_SMP_W-1:0]      adcMain,
  input  wire [`FWER_SMP_W-1:0]      adcTeaser,
  input  wire                        faultTrigger,
  input  wire [31:0]                 faultParam,
  output wire                        captureBusy,
  output wire [`FWER_SLOT_W-1:0]     recCount,
  output wire [`FWER_SLOT_W-1:0]     recNewest,
  input  wire                        timeLoad,
  input  wire [`FWER_TIME_W-1:0]     timeValue,
  output wire [`FWER_TIME_W-1:0]     timeMs,
  input  wire [`FWER_NUM_CODES-1:0]  evtPulse,
  input  wire [15:0]                 tripCurrent,
  input  wire [15:0]                 tripClearTime,
  output wire [`FWER_EVT_AW-1:0]     evCount,
  output wire [`FWER_EVT_AW-1:0]     evOldest,
  input  wire [NUM_ELEM-1:0]         elemOperate,
  output wire [NUM_ELEM*`FWER_CNT_W-1:0] elemCount,
  output wire                        nvWrValid,
  input  wire                        nvWrReady,
  output wire [18:0]                 nvWrAddr,
  output wire [31:0]                 nvWrData,
  output wire                        nvRdValid,
  input  wire                        nvRdReady,
  output wire [18:0]                 nvRdAddr,
  input  wire                        nvRdDataValid,
  input  wire [31:0]                 nvRdData,
  input  wire                        usbReqValid,
  input  wire                        usbReqWave,
  input  wire [18:0]                 usbReqAddr,
  output wire                        usbReqReady,
  output wire                        usbRspValid,
  output wire [83:0]                 usbRspData,
  input  wire                        rsReqValid,
  input  wire                        rsReqWave,
  input  wire [18:0]                 rsReqAddr,
  output wire                        rsReqReady,
  output wire                        rsRspValid,
  output wire [83:0]                 rsRspData
);
  // ************************************************
  // derived sizes
  // ************************************************
  localparam [10:0] BUF_LAST  = `FWER_REC_CYC * `FWER_SPC - 1;
  localparam [11:0] BUF_DEPTH = `FWER_REC_CYC * `FWER_SPC;
  localparam [7:0]  POST_SMP  = `FWER_POST_CYC * `FWER_SPC;
  localparam [10:0] HDR       = `FWER_HDR_WORDS;
  localparam [10:0] LAST_WORD = `FWER_HDR_WORDS +
                                `FWER_REC_CYC * `FWER_SPC - 1;
  localparam [7:0]  REC_LAST  = `FWER_NUM_REC - 1;
  localparam [7:0]  REC_MAX   = `FWER_NUM_REC;
  localparam [12:0] EVT_LAST  = `FWER_NUM_EVT - 1;
  localparam [12:0] EVT_MAX   = `FWER_NUM_EVT;
  localparam [3:0]  EV_TRIP   = `FWER_EV_TRIP;
  localparam CAP_IDLE = 3'h0, CAP_WAIT = 3'h1, CAP_RD = 3'h2;
  localparam CAP_LOAD = 3'h3, CAP_WR = 3'h4;
  localparam H_IDLE = 2'h0, H_EVT = 2'h1, H_NVREQ = 2'h2, H_NVWAIT = 2'h3;

  // ************************************************
  // conversion timer and converter input sync
  // ************************************************
  reg [31:0] smpTmr_q;
  reg        adcConvert_q;
  reg [32:0] adcMeta_q;
  reg [32:0] adcSync_q;
  reg        doneLast_q;
  wire       sampleStb = adcSync_q[32] & ~doneLast_q;
  wire [31:0] sampleWord = adcSync_q[31:0];

  // converter result arrives from outside the clock domain: two stages
  always @(posedge clk) begin
    if (rst) begin
      smpTmr_q     <= 32'h0000_0000;
      adcConvert_q <= 1'h0;
      adcMeta_q    <= 33'h0_0000_0000;
      adcSync_q    <= 33'h0_0000_0000;
      doneLast_q   <= 1'h0;
    end else if (ce) begin
      adcConvert_q <= (smpTmr_q == SAMPLE_TICKS - 32'h0000_0001);
      smpTmr_q     <= (smpTmr_q == SAMPLE_TICKS - 32'h0000_0001) ?
                      32'h0000_0000 : smpTmr_q + 32'h0000_0001;
      adcMeta_q    <= {adcDone, adcMain, adcTeaser};
      adcSync_q    <= adcMeta_q;
      doneLast_q   <= adcSync_q[32];
    end
  end

  // ************************************************
  // time of day in milliseconds
  // ************************************************
  reg [31:0]              msDiv_q;
  reg [`FWER_TIME_W-1:0]  timeMs_q;

  // a load wins over the tick so a synchronised time is never off by one
  always @(posedge clk) begin
    if (rst) begin
      msDiv_q  <= 32'h0000_0000;
      timeMs_q <= 48'h0000_0000_0000;
    end else if (ce) begin
      msDiv_q <= (msDiv_q == MS_TICKS - 32'h0000_0001) ?
                 32'h0000_0000 : msDiv_q + 32'h0000_0001;
      if (timeLoad)
        timeMs_q <= timeValue;
      else if (msDiv_q == MS_TICKS - 32'h0000_0001)
        timeMs_q <= timeMs_q + 48'h0000_0000_0001;
    end
  end

  // ************************************************
  // pre-fault ring and record capture
  // ************************************************
  reg [10:0]  wp_q;
  reg [10:0]  base_q;
  reg [2:0]   cap_q;
  reg [7:0]   postLeft_q;
  reg [10:0]  wordIdx_q;
  reg [7:0]   recHead_q;
  reg [7:0]   recCount_q;
  reg [7:0]   recNewest_q;
  reg [47:0]  stamp_q;
  reg [31:0]  param_q;
  reg [31:0]  seq_q;
  reg [31:0]  nvWrData_q;
  reg [18:0]  nvWrAddr_q;
  reg [31:0]  hdrWord;
  wire [31:0] bufRd;
  wire [10:0] off = wordIdx_q - HDR;
  wire [11:0] rawAddr = {1'h0, base_q} + {1'h0, off};
  wire [11:0] wrapAddr = (rawAddr >= BUF_DEPTH) ?
                         rawAddr - BUF_DEPTH : rawAddr;

  // header words: time stamp, fault parameters, capture sequence
  always @* begin
    case (wordIdx_q[1:0])
      2'h0:    hdrWord = {16'h0000, stamp_q[47:32]};
      2'h1:    hdrWord = stamp_q[31:0];
      2'h2:    hdrWord = param_q;
      default: hdrWord = seq_q;
    endcase
  end

  // the buffer keeps filling during a capture; the copy runs far faster
  // than one sample period, so it finishes before the oldest is reused
  always @(posedge clk) begin
    if (rst) begin
      wp_q        <= 11'h000;
      base_q      <= 11'h000;
      cap_q       <= CAP_IDLE;
      postLeft_q  <= 8'h00;
      wordIdx_q   <= 11'h000;
      recHead_q   <= 8'h00;
      recCount_q  <= 8'h00;
      recNewest_q <= 8'h00;
      stamp_q     <= 48'h0000_0000_0000;
      param_q     <= 32'h0000_0000;
      seq_q       <= 32'h0000_0000;
      nvWrData_q  <= 32'h0000_0000;
      nvWrAddr_q  <= 19'h0_0000;
    end else if (ce) begin
      if (sampleStb)
        wp_q <= (wp_q == BUF_LAST) ? 11'h000 : wp_q + 11'h001;
      case (cap_q)
        CAP_IDLE: begin
          if (faultTrigger) begin
            stamp_q    <= timeMs_q;
            param_q    <= faultParam;
            postLeft_q <= POST_SMP;
            cap_q      <= CAP_WAIT;
          end
        end
        CAP_WAIT: begin
          if (postLeft_q == 8'h00) begin
            base_q    <= wp_q;
            wordIdx_q <= 11'h000;
            cap_q     <= CAP_RD;
          end else if (sampleStb)
            postLeft_q <= postLeft_q - 8'h01;
        end
        CAP_RD: begin
          cap_q <= CAP_LOAD;
        end
        CAP_LOAD: begin
          nvWrData_q <= (wordIdx_q < HDR) ? hdrWord : bufRd;
          nvWrAddr_q <= {recHead_q, wordIdx_q};
          cap_q      <= CAP_WR;
        end
        CAP_WR: begin
          if (nvWrReady) begin
            if (wordIdx_q == LAST_WORD) begin
              recNewest_q <= recHead_q;
              recHead_q   <= (recHead_q == REC_LAST) ? 8'h00 :
                             recHead_q + 8'h01;
              if (recCount_q != REC_MAX)
                recCount_q <= recCount_q + 8'h01;
              seq_q <= seq_q + 32'h0000_0001;
              cap_q <= CAP_IDLE;
            end else begin
              wordIdx_q <= wordIdx_q + 11'h001;
              cap_q     <= CAP_RD;
            end
          end
        end
        default: cap_q <= CAP_IDLE;
      endcase
    end
  end

  fwer_mem #(.W(32), .D(`FWER_REC_CYC * `FWER_SPC), .AW(11)) uBuf (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (sampleStb),
    .wrAddr (wp_q),
    .wrData (sampleWord),
    .rdEn   (cap_q == CAP_RD),
    .rdAddr (wrapAddr[10:0]),
    .rdData (bufRd)
  );

  // ************************************************
  // event logger
  // ************************************************
  reg [`FWER_NUM_CODES-1:0] pend_q;
  reg [`FWER_NUM_CODES-1:0] pickOne;
  reg [3:0]                 pickCode;
  reg [31:0]                tripArg_q;
  reg [12:0]                evHead_q;
  reg [12:0]                evCount_q;
  reg [12:0]                evTail_q;
  wire                      evWr = |pend_q;
  wire [83:0]               evEntry = {timeMs_q, pickCode,
                             (pickCode == EV_TRIP) ? tripArg_q : 32'h0000_0000};
  wire [83:0]               evRd;
  integer                   k;

  // lowest pending kind goes first; others wait a cycle each
  always @* begin
    pickOne  = {`FWER_NUM_CODES{1'h0}};
    pickCode = 4'h0;
    for (k = `FWER_NUM_CODES - 1; k >= 0; k = k - 1) begin
      if (pend_q[k]) begin
        pickOne  = {`FWER_NUM_CODES{1'h0}};
        pickOne[k] = 1'h1;
        pickCode = k[3:0];
      end
    end
  end

  // a fresh pulse wins over the clear of its own pending bit
  genvar g;
  generate
    for (g = 0; g < `FWER_NUM_CODES; g = g + 1) begin : gPend
      always @(posedge clk) begin
        if (rst)
          pend_q[g] <= 1'h0;
        else if (ce)
          pend_q[g] <= evtPulse[g] | (pend_q[g] & ~pickOne[g]);
      end
    end
  endgenerate

  // ring of entries; once full the tail is dragged along with the head
  always @(posedge clk) begin
    if (rst) begin
      tripArg_q <= 32'h0000_0000;
      evHead_q  <= 13'h0000;
      evCount_q <= 13'h0000;
      evTail_q  <= 13'h0000;
    end else if (ce) begin
      if (evtPulse[`FWER_EV_TRIP])
        tripArg_q <= {tripCurrent, tripClearTime};
      if (evWr) begin
        evHead_q <= (evHead_q == EVT_LAST) ? 13'h0000 : evHead_q + 13'h0001;
        if (evCount_q == EVT_MAX)
          evTail_q <= (evTail_q == EVT_LAST) ? 13'h0000 :
                      evTail_q + 13'h0001;
        else
          evCount_q <= evCount_q + 13'h0001;
      end
    end
  end

  // ************************************************
  // host ports, usb has priority over rs485
  // ************************************************
  reg [1:0]  host_q;
  reg        owner_q;
  reg [18:0] nvRdAddr_q;
  reg [83:0] rspData_q;
  reg        usbRsp_q;
  reg        rsRsp_q;
  wire       usbTake = (host_q == H_IDLE) & usbReqValid;
  wire       rsTake  = (host_q == H_IDLE) & rsReqValid & ~usbReqValid;
  wire       take    = usbTake | rsTake;
  wire       takeWave = usbTake ? usbReqWave : rsReqWave;
  wire [18:0] takeAddr = usbTake ? usbReqAddr : rsReqAddr;

  // one request at a time; the answer is a one-cycle pulse to its owner
  always @(posedge clk) begin
    if (rst) begin
      host_q     <= H_IDLE;
      owner_q    <= 1'h0;
      nvRdAddr_q <= 19'h0_0000;
      rspData_q  <= 84'h0;
      usbRsp_q   <= 1'h0;
      rsRsp_q    <= 1'h0;
    end else if (ce) begin
      usbRsp_q <= 1'h0;
      rsRsp_q  <= 1'h0;
      case (host_q)
        H_IDLE: begin
          if (take) begin
            owner_q    <= rsTake;
            nvRdAddr_q <= takeAddr;
            host_q     <= takeWave ? H_NVREQ : H_EVT;
          end
        end
        H_EVT: begin
          rspData_q <= evRd;
          usbRsp_q  <= ~owner_q;
          rsRsp_q   <= owner_q;
          host_q    <= H_IDLE;
        end
        H_NVREQ: begin
          if (nvRdReady)
            host_q <= H_NVWAIT;
        end
        H_NVWAIT: begin
          if (nvRdDataValid) begin
            rspData_q <= {52'h0_0000_0000_0000, nvRdData};
            usbRsp_q  <= ~owner_q;
            rsRsp_q   <= owner_q;
            host_q    <= H_IDLE;
          end
        end
        default: host_q <= H_IDLE;
      endcase
    end
  end

  fwer_mem #(.W(84), .D(`FWER_NUM_EVT), .AW(13)) uLog (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (evWr),
    .wrAddr (evHead_q),
    .wrData (evEntry),
    .rdEn   (take & ~takeWave),
    .rdAddr (takeAddr[12:0]),
    .rdData (evRd)
  );

  // ************************************************
  // operation counters, one per element
  // ************************************************
  generate
    for (g = 0; g < NUM_ELEM; g = g + 1) begin : gCnt
      reg [`FWER_CNT_W-1:0] cnt_q;
      always @(posedge clk) begin
        if (rst)
          cnt_q <= 16'h0000;
        else if (ce && elemOperate[g])
          cnt_q <= cnt_q + 16'h0001;
      end
      assign elemCount[g*`FWER_CNT_W +: `FWER_CNT_W] = cnt_q;
    end
  endgenerate

  // ************************************************
  // outputs
  // ************************************************
  assign adcConvert  = adcConvert_q;
  assign captureBusy = (cap_q != CAP_IDLE);
  assign recCount    = recCount_q;
  assign recNewest   = recNewest_q;
  assign timeMs      = timeMs_q;
  assign evCount     = evCount_q;
  assign evOldest    = evTail_q;
  assign nvWrValid   = (cap_q == CAP_WR);
  assign nvWrAddr    = nvWrAddr_q;
  assign nvWrData    = nvWrData_q;
  assign nvRdValid   = (host_q == H_NVREQ);
  assign nvRdAddr    = nvRdAddr_q;
  assign usbReqReady = usbTake;
  assign rsReqReady  = rsTake;
  assign usbRspValid = usbRsp_q;
  assign rsRspValid  = rsRsp_q;
  assign usbRspData  = rspData_q;
  assign rsRspData   = rspData_q;
endmodule

// ===== verif/fwer_adc_model.sv
// converter model answering start pulses with paired results
`timescale 1ns/1ps
module fwer_adc_model (
  input  wire        clk,
  input  wire        adcConvert,
  output reg         adcDone,
  output reg  [15:0] adcMain,
  output reg  [15:0] adcTeaser,
  output reg  [15:0] sampleIdx
);
  integer waitN;

  // slow or prompt conversion; lines invert once results lapse
  initial begin
    adcDone = 1'b0;
    adcMain = 16'h0000;
    adcTeaser = 16'hffff;
    sampleIdx = 16'h0000;
    forever begin
      @(negedge clk);
      if (adcConvert === 1'b1) begin
        waitN = $urandom_range(1, 8);
        repeat (waitN) @(negedge clk);
        adcMain = sampleIdx;
        adcTeaser = ~sampleIdx;
        adcDone = 1'b1;
        sampleIdx = sampleIdx + 16'h0001;
        repeat (4) @(negedge clk);
        adcDone = 1'b0;
        adcMain = ~adcMain;
        adcTeaser = ~adcTeaser;
      end
    end
  end
endmodule

// ===== verif/fwer_top_props.sv
// assertions on the recorder top ports
`timescale 1ns/1ps
`include "fwer_regs.vh"
module fwer_top_props #(
  parameter [31:0] SAMPLE_TICKS = 32'h0000_0028,
  parameter        NUM_ELEM     = 1
) (
  input wire                            clk,
  input wire                            rst,
  input wire                            adcConvert,
  input wire                            faultTrigger,
  input wire                            captureBusy,
  input wire [`FWER_SLOT_W-1:0]         recCount,
  input wire                            timeLoad,
  input wire [`FWER_TIME_W-1:0]         timeValue,
  input wire [`FWER_TIME_W-1:0]         timeMs,
  input wire [`FWER_EVT_AW-1:0]         evCount,
  input wire [NUM_ELEM-1:0]             elemOperate,
  input wire [NUM_ELEM*`FWER_CNT_W-1:0] elemCount,
  input wire                            nvWrValid,
  input wire                            nvWrReady,
  input wire [18:0]                     nvWrAddr,
  input wire [31:0]                     nvWrData,
  input wire                            usbReqValid,
  input wire                            usbReqWave,
  input wire                            usbReqReady,
  input wire                            usbRspValid
);
  // ************
  // helper logic
  // ************
  reg [31:0] gapCnt_q;
  reg        seen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // cycles since last conversion start; the first one is not timed
  always @(posedge clk) begin
    if (rst) begin
      gapCnt_q <= 32'h0000_0000;
      seen_q   <= 1'b0;
    end else if (adcConvert) begin
      gapCnt_q <= 32'h0000_0000;
      seen_q   <= 1'b1;
    end else begin
      gapCnt_q <= gapCnt_q + 32'h0000_0001;
    end
  end

  adc_period_a: assert property (
    adcConvert && seen_q |-> gapCnt_q == SAMPLE_TICKS - 1)
    else $error("conversion period wrong");
  busy_start_a: assert property (
    faultTrigger && !captureBusy |=> captureBusy)
    else $error("trigger not taken");
  nv_hold_a: assert property (
    nvWrValid && !nvWrReady |=>
      nvWrValid && $stable(nvWrAddr) && $stable(nvWrData))
    else $error("storage write not held");
  nv_spacing_a: assert property (
    nvWrValid && nvWrReady |=> !nvWrValid [*2])
    else $error("storage write spacing wrong");
  rec_limit_a: assert property (
    recCount <= `FWER_NUM_REC)
    else $error("record count above capacity");
  ev_limit_a: assert property (
    evCount <= `FWER_NUM_EVT)
    else $error("event count above capacity");
  ev_step_a: assert property (
    $changed(evCount) |-> evCount == $past(evCount) + 1)
    else $error("event count jumped");
  time_step_a: assert property (
    !$past(timeLoad) && $changed(timeMs) |->
      timeMs == $past(timeMs) + 48'h0000_0000_0001)
    else $error("time of day jumped");
  time_load_a: assert property (
    timeLoad |=> timeMs == $past(timeValue))
    else $error("time load lost");
  elem_count_a: assert property (
    elemOperate[0] |=>
      elemCount[15:0] == $past(elemCount[15:0]) + 16'h0001)
    else $error("operation counter not bumped");
  ev_answer_a: assert property (
    usbReqValid && usbReqReady && !usbReqWave |-> ##[2:3] usbRspValid)
    else $error("event answer late");

  cover property (faultTrigger && !captureBusy);
  cover property (nvWrValid && !nvWrReady);
  cover property (evCount == `FWER_NUM_EVT);
  cover property (usbRspValid);
endmodule

bind fwer_top fwer_top_props #(
  .SAMPLE_TICKS(SAMPLE_TICKS), .NUM_ELEM(NUM_ELEM)) chk (
  .clk, .rst, .adcConvert, .faultTrigger, .captureBusy, .recCount,
  .timeLoad, .timeValue, .timeMs, .evCount, .elemOperate, .elemCount,
  .nvWrValid, .nvWrReady, .nvWrAddr, .nvWrData, .usbReqValid,
  .usbReqWave, .usbReqReady, .usbRspValid);

// ===== verif/tb_fault_waveform_event_recorder.sv
// self-checking bench of the recorder top
`timescale 1ns/1ps
`include "fwer_regs.vh"
`define CHK(nm, e, g) begin \
  compares = compares + 1; \
  if ((g) !== (e)) begin \
    failCount = failCount + 1; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_fault_waveform_event_recorder;
  localparam [31:0] ST  = 32'h0000_0018;
  localparam        LIM = 60000;
  reg         clk, rst, faultTrigger, timeLoad, nvWrReady, nvRdReady;
  reg         nvRdDataValid, usbReqValid, usbReqWave, rsReqValid, rsReqWave;
  reg  [0:0]  elemOperate;
  reg  [8:0]  evtPulse;
  reg  [15:0] tripCurrent, tripClearTime;
  reg  [18:0] usbReqAddr, rsReqAddr, rdAddr;
  reg  [31:0] faultParam, nvRdData, w, p;
  reg  [35:0] e;
  reg  [47:0] t;
  reg  [83:0] d;
  wire        adcConvert, adcDone, captureBusy, nvWrValid, nvRdValid;
  wire        usbReqReady, usbRspValid, rsReqReady, rsRspValid;
  wire [7:0]  recCount, recNewest;
  wire [12:0] evCount, evOldest;
  wire [15:0] adcMain, adcTeaser, sampleIdx, elemCount;
  wire [18:0] nvWrAddr, nvRdAddr;
  wire [31:0] nvWrData;
  wire [47:0] timeMs;
  wire [83:0] usbRspData, rsRspData;
  integer     failCount, compares, rdWait, n, i, k, trig;
  reg  [31:0] nvMem [int];
  reg  [18:0] wrLog [$];
  reg  [35:0] evModel [$];

  fwer_top #(.SAMPLE_TICKS(ST), .MS_TICKS(10), .NUM_ELEM(1)) dut (
    .clk, .rst, .ce(1'b1), .adcConvert, .adcDone, .adcMain, .adcTeaser,
    .faultTrigger, .faultParam, .captureBusy, .recCount, .recNewest,
    .timeLoad, .timeValue(t), .timeMs, .evtPulse, .tripCurrent,
    .tripClearTime, .evCount, .evOldest, .elemOperate, .elemCount,
    .nvWrValid, .nvWrReady, .nvWrAddr, .nvWrData, .nvRdValid, .nvRdReady,
    .nvRdAddr, .nvRdDataValid, .nvRdData, .usbReqValid, .usbReqWave,
    .usbReqAddr, .usbReqReady, .usbRspValid, .usbRspData, .rsReqValid,
    .rsReqWave, .rsReqAddr, .rsReqReady, .rsRspValid, .rsRspData);
  fwer_adc_model adc (.clk, .adcConvert, .adcDone, .adcMain, .adcTeaser,
    .sampleIdx);

  // ****************************
  // storage partner and clocking
  // ****************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // accepts are judged at the rising edge, where the design sees them;
  // by the falling edge valid has already dropped after an accept
  always @(posedge clk) begin
    if (nvWrValid && nvWrReady) begin
      nvMem[nvWrAddr] = nvWrData;
      wrLog.push_back(nvWrAddr);
    end
    if (nvRdValid && nvRdReady) begin
      rdAddr = nvRdAddr;
      rdWait = 3;
    end
  end

  // ready and read data only move on the falling edge
  always @(negedge clk) begin
    nvRdDataValid <= rdWait == 1;
    nvRdData <= (rdWait == 1) ? nvMem[rdAddr] : ~nvRdData;
    if (rdWait > 0) rdWait = rdWait - 1;
    nvWrReady <= $urandom_range(0, 3) != 0;
    nvRdReady <= $urandom_range(0, 1);
  end

  task finalReport;
    begin
      $display("compares %0d failCount %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // request held until taken, then its answer is collected
  task hostReq(input rs, input wave, input [18:0] a);
    begin
      @(negedge clk);
      rsReqValid = rs;
      usbReqValid = !rs;
      {rsReqWave, usbReqWave} = {wave, wave};
      {rsReqAddr, usbReqAddr} = {a, a};
      n = 0;
      #1;
      while ((rs ? rsReqReady : usbReqReady) !== 1'b1 && n < LIM) begin
        @(negedge clk);
        #1;
        n = n + 1;
      end
      @(negedge clk);
      {rsReqValid, usbReqValid} = 2'b00;
      while ((rs ? rsRspValid : usbRspValid) !== 1'b1 && n < LIM) begin
        @(negedge clk);
        n = n + 1;
      end
      d = rs ? rsRspData : usbRspData;
      limitCheck;
    end
  endtask

  // a used-up wait is a mismatch and ends the run at once
  task limitCheck;
    begin
      if (n >= LIM) begin
        failCount = failCount + 1;
        finalReport;
      end
    end
  endtask

  // *************
  // main sequence
  // *************
  initial begin
    {rst, faultTrigger, timeLoad, nvWrReady, nvRdReady} = 5'b10000;
    {nvRdDataValid, usbReqValid, usbReqWave, rsReqValid} = 4'h0;
    {rsReqWave, elemOperate, evtPulse} = 11'h000;
    {tripCurrent, tripClearTime, faultParam, nvRdData} = 0;
    {usbReqAddr, rsReqAddr, t} = 0;
    {failCount, compares, rdWait, n} = 0;
    k = $urandom(79478);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK("evCount", 13'h0000, evCount)
    `CHK("recCount", 8'h00, recCount)
    t = {$urandom, $urandom};
    timeLoad = 1'b1;
    @(negedge clk);
    timeLoad = 1'b0;
    `CHK("timeLoad", t, timeMs)
    repeat (100) @(negedge clk);
    `CHK("msTick", 1'b1, timeMs - t >= 9 && timeMs - t <= 10)
    {tripCurrent, tripClearTime} = $urandom;
    evtPulse = 9'h1ff;
    @(negedge clk);
    evtPulse = 9'h000;
    for (i = 0; i < 9; i = i + 1) begin
      p = (i == 0) ? {tripCurrent, tripClearTime} : 32'h0000_0000;
      evModel.push_back({i[3:0], p});
    end
    repeat (12) @(negedge clk);
    `CHK("evCount", 13'h0009, evCount)
    for (i = 0; i < 9; i = i + 1) begin
      hostReq(i[0], 1'b0, i[18:0]);
      e = evModel.pop_front();
      `CHK("evEntry", e, d[35:0])
    end
    k = $urandom_range(3, 20);
    for (i = 0; i < k; i = i + 1) begin
      elemOperate = 1'b1;
      @(negedge clk);
      elemOperate = 1'b0;
      @(negedge clk);
    end
    `CHK("elemCount", k[15:0], elemCount)
    n = 0;
    while (sampleIdx < 1700 && n < LIM) begin
      @(negedge clk);
      n = n + 1;
    end
    limitCheck;
    faultParam = $urandom;
    faultTrigger = 1'b1;
    t = timeMs; // stamp the record must carry
    trig = sampleIdx;
    @(negedge clk);
    faultTrigger = 1'b0;
    repeat (5) @(negedge clk);
    faultTrigger = 1'b1;
    @(negedge clk);
    faultTrigger = 1'b0;
    n = 0;
    while (captureBusy !== 1'b0 && n < LIM) begin
      @(negedge clk);
      n = n + 1;
    end
    limitCheck;
    `CHK("recCount", 8'h01, recCount)
    `CHK("words", 1604, wrLog.size())
    `CHK("param", faultParam, nvMem[{recNewest, 11'h002}])
    `CHK("stampHi", t[47:32], nvMem[{recNewest, 11'h000}])
    `CHK("stampLo", t[31:0], nvMem[{recNewest, 11'h001}])
    `CHK("seq", 32'h0000_0000, nvMem[{recNewest, 11'h003}])
    for (i = 0; i < 1604; i = i + 1) begin
      `CHK("wrAddr", {recNewest, i[10:0]}, wrLog[i])
      w = nvMem[{recNewest, i[10:0]}];
      if (i >= 4) `CHK("pair", ~w[31:16], w[15:0])
      if (i > 4) `CHK("next", p[31:16] + 16'h0001, w[31:16])
      p = w;
    end
    k = p[31:16] - trig;
    `CHK("post", 1'b1, k >= 156 && k <= 161)
    hostReq(1'b0, 1'b1, {recNewest, 11'h002});
    `CHK("waveRead", faultParam, d[31:0])
    for (i = 0; i < 5010; i = i + 1) begin
      evtPulse = 9'h040;
      @(negedge clk);
      evtPulse = 9'h000;
      @(negedge clk);
    end
    repeat (12) @(negedge clk);
    `CHK("evCount", 13'h1388, evCount)
    `CHK("evOldest", 13'h0013, evOldest)
    hostReq(1'b1, 1'b0, 19'h0_0013);
    `CHK("oldCode", 4'h6, d[35:32])
    if (n >= LIM) failCount = failCount + 1;
    finalReport;
  end
endmodule
